// file: hw/pll_holdover_vco_calibration.sv
// Summary of operation
// - with auto holdover enabled, lock loss puts charge pump high impedance.
// - entry uses sensed lock pin; comparator off means pin reads high.
// - holdover keeps charge pump high impedance while no reference arrives.
// - leaving on a reference event resets swallow counter; prescaler untouched.
// - no re-entry until lock returns and lock pin is high.
// - only the selected reference releases holdover, on its next event.
// - two-bit count sets in-window cycles for lock; 00 is five; window bit.
// - lock pin field value 000100b selects current source lock mode.
// - external holdover bit set selects external, clear selects automatic.
// - holdover enable bit gates automatic holdover; there is no external holdover logic here.
// - auto switchover enable, preferred reference bit, two buffer enables.
// - one bit selects normal or extended reference monitor thresholds.
// - three low-frequency monitors; oscillator one watches clock input if used.
// - power-up load strap starts calibration; needs a live reference.
// - readback status bit reads 1 once calibration has finished.
// - calibration holds output sync, tunes, releases sync, closes loop.
// - cal clock is phase detector rate over 2, 4, 8 or 16, picked by the two-bit divider setting.
// - calibration lasts 4400 cal clock cycles.
// - no self-started calibration when divider or reference settings change.
`default_nettype none
module pll_holdover_vco_calibration
    import pll_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [9:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    // lock sensing and power-up strap
    input  wire logic       lockPinLevel,
    input  wire logic       autoLoadStrap,
    // phase detector events
    input  wire logic       pdCycle,
    input  wire logic       pdInWindow,
    input  wire logic       refEdgeSelected,
    // monitored clock edges
    input  wire logic       firstRefEdge,
    input  wire logic       secondRefEdge,
    input  wire logic       vcoEdge,
    input  wire logic       clkInEdge,
    input  wire logic       clkInSelected,
    // loop control
    output logic            chargePumpHiZ,
    output logic            swallowReset,
    output logic            outputSync,
    output logic            calLoopOpen,
    output logic            calDone,
    output logic            holdoverActive,
    // lock detect configuration
    output logic            digitalLockFlag,
    output logic            lockWindowHigh,
    output logic      [5:0] lockPinMode,
    output logic            currentSourceLockMode,
    // reference selection and monitors
    output logic            autoSwitchEn,
    output logic            preferSecondRef,
    output logic      [1:0] refBufEnable,
    output logic            extThreshSel,
    output logic            firstRefLow,
    output logic            secondRefLow,
    output logic            vcoClkLow
);
    typedef struct packed {
        logic [7:0]  shLockCal;
        logic [7:0]  shPinMon;
        logic [7:0]  shRefSel;
        logic [7:0]  shHold;
        logic [7:0]  acLockCal;
        logic [7:0]  acPinMon;
        logic [7:0]  acRefSel;
        logic [7:0]  acHold;
        logic [7:0]  rdata;
        logic [7:0]  lockCnt;
        logic        lock;
        holdState_t  hold;
        logic        hiZ;
        logic        swallow;
        calState_t   cal;
        logic        sync;
        logic        loopOpen;
        logic        done;
        logic        strapSeen;
    } ctrlState_t;

    ctrlState_t  s_q;
    ctrlState_t  s_d;
    logic        ldSensed;
    logic        holdEn;
    logic        extSel;
    logic        updateWr;
    logic        calReq;
    logic [7:0]  lockTarget;
    logic [15:0] monThresh;
    logic        oscEdge;

    cal_if calBus ();

    ////////////////////////////////////////////////////////////////
    // decoded controls
    assign holdEn   = s_q.acHold[HOLD_EN_BIT];
    assign extSel   = s_q.acHold[EXT_HOLD_BIT];
    assign ldSensed = s_q.acHold[CMP_EN_BIT] ? lockPinLevel : 1'b1;
    assign updateWr = regWrite && regAddr == ADDR_UPDATE
                      && regWdata[UPDATE_BIT];
    assign lockTarget = LOCK_CYCLES[s_q.acLockCal[LOCK_CNT_LSB +: 2]];
    assign monThresh  = s_q.acPinMon[THRESH_BIT] ? MON_THRESH_EXTENDED
                                                 : MON_THRESH_NORMAL;
    assign oscEdge    = clkInSelected ? clkInEdge : vcoEdge;

    // request on 0 to 1 of calibrate bit at update, or power-up strap
    assign calReq = (updateWr && s_q.shLockCal[CAL_BIT]
                     && !s_q.acLockCal[CAL_BIT])
                    || (!s_q.strapSeen && autoLoadStrap);

    ////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.swallow = 1'b0;
        s_d.strapSeen = 1'b1;
        // register writes land in the shadow copy
        if (regWrite) begin
            unique case (regAddr)
                ADDR_LOCK_CAL: s_d.shLockCal = regWdata & MASK_LOCK_CAL;
                ADDR_PIN_MON:  s_d.shPinMon  = regWdata & MASK_PIN_MON;
                ADDR_REF_SEL:  s_d.shRefSel  = regWdata & MASK_REF_SEL;
                ADDR_HOLD:     s_d.shHold    = regWdata & MASK_HOLD;
                default:       ;
            endcase
        end
        if (updateWr) begin
            s_d.acLockCal = s_q.shLockCal;
            s_d.acPinMon  = s_q.shPinMon;
            s_d.acRefSel  = s_q.shRefSel;
            s_d.acHold    = s_q.shHold;
        end
        // register readback
        unique case (regAddr)
            ADDR_LOCK_CAL: s_d.rdata = s_q.shLockCal;
            ADDR_PIN_MON:  s_d.rdata = s_q.shPinMon;
            ADDR_REF_SEL:  s_d.rdata = s_q.shRefSel;
            ADDR_HOLD:     s_d.rdata = s_q.shHold;
            ADDR_READBACK: begin
                s_d.rdata = '0;
                s_d.rdata[RB_LOCK_BIT] = s_q.lock;
                s_d.rdata[RB_HOLD_BIT] = s_q.hiZ;
                s_d.rdata[RB_MON_LSB +: 3] =
                    {vcoClkLow, secondRefLow, firstRefLow};
                s_d.rdata[RB_CAL_BIT] = s_q.done;
            end
            default:       s_d.rdata = '0;
        endcase

        ////////////////////////////////////////////////////////////
        // digital lock: consecutive in-window cycles
        if (s_q.acLockCal[DLD_OFF_BIT]) begin
            s_d.lockCnt = '0;
            s_d.lock = 1'b0;
        end else if (pdCycle) begin
            if (!pdInWindow) begin
                s_d.lockCnt = '0;
                s_d.lock = 1'b0;
            end else if (s_q.lockCnt != lockTarget) begin
                s_d.lockCnt = s_q.lockCnt + 8'h01;
                s_d.lock = (s_d.lockCnt == lockTarget);
            end
        end

        ////////////////////////////////////////////////////////////
        // automatic holdover
        if (!holdEn) begin
            s_d.hold = H_REARM;
            s_d.hiZ = 1'b0;
        end else begin
            unique case (s_q.hold)
                H_REARM: begin
                    if (s_q.lock && ldSensed) begin
                        s_d.hold = H_ARMED;
                    end
                end
                H_ARMED: begin
                    if (!extSel && ldSensed && !s_q.lock) begin
                        s_d.hold = H_HOLD;
                        s_d.hiZ = 1'b1;
                    end
                end
                H_HOLD: begin
                    if (refEdgeSelected) begin
                        s_d.hold = H_REARM;
                        s_d.hiZ = 1'b0;
                        s_d.swallow = 1'b1;
                    end
                end
                default: begin
                    s_d.hold = H_REARM;
                    s_d.hiZ = 1'b0;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////
        // calibration sequence
        unique case (s_q.cal)
            C_IDLE: begin
                s_d.loopOpen = 1'b0;
                if (calReq) begin
                    s_d.cal = C_TUNE;
                    s_d.sync = 1'b1;
                    s_d.loopOpen = 1'b1;
                    s_d.done = 1'b0;
                end
            end
            C_TUNE: begin
                if (calBus.done) begin
                    s_d.cal = C_RELEASE;
                    s_d.sync = 1'b0;
                end
            end
            C_RELEASE: begin
                s_d.cal = C_IDLE;
                s_d.loopOpen = 1'b0;
                s_d.done = 1'b1;
            end
            default: begin
                s_d.cal = C_IDLE;
                s_d.sync = 1'b0;
                s_d.loopOpen = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{shLockCal: RESET_REG, shPinMon: RESET_REG,
                     shRefSel: RESET_REG, shHold: RESET_REG,
                     acLockCal: RESET_REG, acPinMon: RESET_REG,
                     acRefSel: RESET_REG, acHold: RESET_REG,
                     rdata: '0, lockCnt: '0, lock: 1'b0,
                     hold: H_REARM, hiZ: 1'b0, swallow: 1'b0,
                     cal: C_IDLE, sync: 1'b0, loopOpen: 1'b0,
                     done: 1'b0, strapSeen: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // calibration timer and monitors
    assign calBus.pdTick = pdCycle;
    assign calBus.calDiv = s_q.acLockCal[CAL_DIV_LSB +: 2];
    assign calBus.start  = s_q.cal == C_IDLE && calReq;

    cal_timer u_calTimer (
        .clk (clk),
        .rst (rst),
        .cal (calBus)
    );

    freq_monitor u_firstMon (
        .clk         (clk),
        .rst         (rst),
        .monEdge     (firstRefEdge),
        .thresh      (monThresh),
        .belowThresh (firstRefLow)
    );

    freq_monitor u_secondMon (
        .clk         (clk),
        .rst         (rst),
        .monEdge     (secondRefEdge),
        .thresh      (monThresh),
        .belowThresh (secondRefLow)
    );

    freq_monitor u_oscMon (
        .clk         (clk),
        .rst         (rst),
        .monEdge     (oscEdge),
        .thresh      (monThresh),
        .belowThresh (vcoClkLow)
    );

    ////////////////////////////////////////////////////////////////
    // outputs
    assign regRdata        = s_q.rdata;
    assign chargePumpHiZ   = s_q.hiZ;
    assign holdoverActive  = s_q.hiZ;
    assign swallowReset    = s_q.swallow;
    assign outputSync      = s_q.sync;
    assign calLoopOpen     = s_q.loopOpen;
    assign calDone         = s_q.done;
    assign digitalLockFlag = s_q.lock;
    assign lockWindowHigh  = !s_q.acLockCal[WINDOW_BIT];
    assign lockPinMode     = s_q.acPinMon[PIN_MODE_LSB +: 6];
    assign currentSourceLockMode =
        lockPinMode == PIN_MODE_CURRENT;
    assign autoSwitchEn    = s_q.acRefSel[AUTO_SW_BIT];
    assign preferSecondRef = s_q.acRefSel[PREFER_BIT];
    assign refBufEnable    = s_q.acRefSel[BUF_LSB +: 2];
    assign extThreshSel    = s_q.acPinMon[THRESH_BIT];

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seqSyncRelease;
        !outputSync && calLoopOpen ##1 !calLoopOpen && calDone;
    endsequence

    chk_hold_entry: assert property (
        s_q.hold == H_ARMED && holdEn && !extSel && ldSensed
        && !digitalLockFlag |=> chargePumpHiZ)
        else $error("holdover not entered on lock loss");
    chk_ld_masked: assert property (
        !s_q.acHold[CMP_EN_BIT] && s_q.hold == H_ARMED && holdEn
        && !extSel && !digitalLockFlag && !lockPinLevel |=> chargePumpHiZ)
        else $error("disabled comparator blocked holdover");
    chk_hiz_no_ref: assert property (
        chargePumpHiZ && holdEn && !refEdgeSelected |=> chargePumpHiZ)
        else $error("charge pump released without reference");
    chk_swallow_exit: assert property (
        chargePumpHiZ && holdEn && refEdgeSelected
        |=> swallowReset && !chargePumpHiZ ##1 !swallowReset)
        else $error("swallow reset not paired with release");
    chk_no_reentry: assert property (
        swallowReset && !digitalLockFlag |-> !chargePumpHiZ [*3])
        else $error("holdover re-entered before relock");
    chk_ext_sel: assert property (
        extSel && !chargePumpHiZ |=> !chargePumpHiZ)
        else $error("automatic holdover acted in external mode");
    chk_hold_gate: assert property (
        !holdEn |=> !chargePumpHiZ)
        else $error("holdover active while disabled");
    chk_lock_count: assert property (
        $rose(digitalLockFlag) |-> $past(pdCycle && pdInWindow)
        && $past(s_q.lockCnt) == lockTarget - 8'h01)
        else $error("lock flag rose at wrong count");
    chk_cal_sync: assert property (
        calBus.start |=> outputSync && calLoopOpen)
        else $error("sync not asserted at calibration start");
    chk_sync_order: assert property (
        $fell(outputSync) |-> seqSyncRelease)
        else $error("loop closed out of order");
    chk_done_clear: assert property (
        calBus.start |=> !calDone [*2])
        else $error("finished bit not cleared on request");
    chk_no_self_cal: assert property (
        $rose(outputSync) |-> $past(updateWr || !s_q.strapSeen))
        else $error("calibration started without request");
endmodule : pll_holdover_vco_calibration
`default_nettype wire

// file: common/pll_ctrl_pkg.sv
`default_nettype none
package pll_ctrl_pkg;
    // register addresses
    localparam logic [9:0] ADDR_LOCK_CAL   = 10'h018;
    localparam logic [9:0] ADDR_PIN_MON    = 10'h01A;
    localparam logic [9:0] ADDR_REF_SEL    = 10'h01C;
    localparam logic [9:0] ADDR_HOLD       = 10'h01D;
    localparam logic [9:0] ADDR_READBACK   = 10'h01F;
    localparam logic [9:0] ADDR_UPDATE     = 10'h232;
    // writable bit masks, reset values
    localparam logic [7:0] MASK_LOCK_CAL   = 8'h7F;
    localparam logic [7:0] MASK_PIN_MON    = 8'h7F;
    localparam logic [7:0] MASK_REF_SEL    = 8'h1E;
    localparam logic [7:0] MASK_HOLD       = 8'h0B;
    localparam logic [7:0] RESET_REG       = 8'h00;
    // field positions
    localparam int CAL_BIT       = 0;
    localparam int CAL_DIV_LSB   = 1;
    localparam int DLD_OFF_BIT   = 3;
    localparam int WINDOW_BIT    = 4;
    localparam int LOCK_CNT_LSB  = 5;
    localparam int PIN_MODE_LSB  = 0;
    localparam int THRESH_BIT    = 6;
    localparam int BUF_LSB       = 1;
    localparam int PREFER_BIT    = 3;
    localparam int AUTO_SW_BIT   = 4;
    localparam int HOLD_EN_BIT   = 0;
    localparam int EXT_HOLD_BIT  = 1;
    localparam int CMP_EN_BIT    = 3;
    localparam int UPDATE_BIT    = 0;
    localparam int RB_LOCK_BIT   = 0;
    localparam int RB_HOLD_BIT   = 1;
    localparam int RB_MON_LSB    = 2;
    localparam int RB_CAL_BIT    = 6;
    // encodings and counts
    localparam logic [5:0] PIN_MODE_CURRENT = 6'h04;
    localparam logic [7:0] LOCK_CYCLES [4] =
        '{8'h05, 8'h10, 8'h40, 8'hFF};
    localparam logic [4:0] CAL_DIV_VALUES [4] =
        '{5'h02, 5'h04, 5'h08, 5'h10};
    localparam logic [12:0] CAL_CYCLES = 13'h1130;
    localparam logic [15:0] MON_THRESH_NORMAL   = 16'h0400;
    localparam logic [15:0] MON_THRESH_EXTENDED = 16'h4000;
    // state types
    typedef enum logic [1:0] {H_REARM, H_ARMED, H_HOLD} holdState_t;
    typedef enum logic [1:0] {C_IDLE, C_TUNE, C_RELEASE} calState_t;
endpackage : pll_ctrl_pkg
`default_nettype wire

// file: common/cal_if.sv
`default_nettype none
interface cal_if;
    logic       pdTick;
    logic [1:0] calDiv;
    logic       start;
    logic       done;
    logic       busy;
    modport ctrl  (output pdTick, calDiv, start, input done, busy);
    modport timer (input pdTick, calDiv, start, output done, busy);
endinterface : cal_if
`default_nettype wire

// file: hw/freq_monitor.sv
`default_nettype none
module freq_monitor
    import pll_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // monitored clock edge and limit
    input  wire logic        monEdge,
    input  wire logic [15:0] thresh,
    // status
    output logic             belowThresh
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        below;
    } monState_t;

    monState_t s_q;
    monState_t s_d;

    always_comb begin
        s_d = s_q;
        if (monEdge) begin
            s_d.cnt = '0;
            s_d.below = 1'b0;
        end else if (s_q.cnt < thresh) begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_d.cnt == thresh) begin
                s_d.below = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign belowThresh = s_q.below;

    chk_mon_late_edge: assert property (@(posedge clk) disable iff (rst)
        $rose(belowThresh) |-> $past(s_q.cnt) == thresh - 16'h0001)
        else $error("monitor flagged before threshold count");
endmodule : freq_monitor
`default_nettype wire

// file: hw/cal_timer.sv
`default_nettype none
module cal_timer
    import pll_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control side
    cal_if.timer      cal
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [4:0]  divCnt;
        logic [12:0] cycCnt;
    } timerState_t;

    timerState_t s_q;
    timerState_t s_d;
    logic [4:0]  divVal;

    assign divVal = CAL_DIV_VALUES[cal.calDiv];

    ////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (cal.start) begin
            s_d.busy = 1'b1;
            s_d.divCnt = '0;
            s_d.cycCnt = '0;
        end else if (s_q.busy && cal.pdTick) begin
            // phase detector rate divided down to the cal clock
            if (s_q.divCnt == divVal - 5'h01) begin
                s_d.divCnt = '0;
                if (s_q.cycCnt == CAL_CYCLES - 13'h0001) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end else begin
                    s_d.cycCnt = s_q.cycCnt + 13'h0001;
                end
            end else begin
                s_d.divCnt = s_q.divCnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cal.busy = s_q.busy;
    assign cal.done = s_q.done;

    ////////////////////////////////////////////////////////////////
    chk_cal_length: assert property (@(posedge clk) disable iff (rst)
        cal.done |-> $past(s_q.cycCnt) == CAL_CYCLES - 13'h0001
            && $past(cal.pdTick) && !cal.busy)
        else $error("calibration ended at wrong cycle count");
endmodule : cal_timer
`default_nettype wire

// file: bench/pll_far_end.sv
`default_nettype none
module pll_far_end (
    // clock
    input  wire logic clk,
    // phase detector and monitored edges
    output logic      pdCycle,
    output logic      pdInWindow,
    output logic      refEdgeSelected,
    output logic      firstRefEdge,
    output logic      vcoEdge
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // live reference and oscillator follow the detector rate
    assign firstRefEdge = pdCycle;
    assign vcoEdge      = pdCycle;

    initial begin
        pdCycle         = 1'h0;
        pdInWindow      = 1'h0;
        refEdgeSelected = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // detector cycles, window level inverted between events
    task automatic pulse(input int n, input logic win);
        repeat (n) begin
            @(posedge clk);
            pdCycle    <= 1'h1;
            pdInWindow <= win;
            @(posedge clk);
            pdCycle    <= 1'h0;
            pdInWindow <= ~win;
        end
    endtask : pulse

    // one reference-path event of the selected reference
    task automatic refPulse();
        @(posedge clk);
        refEdgeSelected <= 1'h1;
        @(posedge clk);
        refEdgeSelected <= 1'h0;
    endtask : refPulse
endmodule : pll_far_end
`default_nettype wire

// file: bench/tb_top.sv
`default_nettype none
module tb_top
    import pll_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'h0, rst = 1'h1, regWrite = 1'h0, lockPinLevel = 1'h1;
    logic       autoLoadStrap = 1'h0, clkInSelected = 1'h0;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWdata = 8'h00, regRdata, v;
    logic       pdCycle, pdInWindow, refEdgeSelected, firstRefEdge, vcoEdge;
    logic       chargePumpHiZ, swallowReset, outputSync, calLoopOpen;
    logic       calDone, holdoverActive, digitalLockFlag, lockWindowHigh;
    logic       currentSourceLockMode, autoSwitchEn, preferSecondRef;
    logic       extThreshSel, firstRefLow, secondRefLow, vcoClkLow;
    logic [5:0] lockPinMode;
    logic [1:0] refBufEnable;
    int         errorCnt = 0, checked = 0;

    always #4 clk = ~clk;

    pll_far_end fe (.clk, .pdCycle, .pdInWindow, .refEdgeSelected,
        .firstRefEdge, .vcoEdge);

    pll_holdover_vco_calibration dut (.clk, .rst, .regAddr, .regWrite,
        .regWdata, .regRdata, .lockPinLevel, .autoLoadStrap, .pdCycle,
        .pdInWindow, .refEdgeSelected, .firstRefEdge, .secondRefEdge(1'h0),
        .vcoEdge, .clkInEdge(1'h0), .clkInSelected, .chargePumpHiZ,
        .swallowReset, .outputSync, .calLoopOpen, .calDone, .holdoverActive,
        .digitalLockFlag, .lockWindowHigh, .lockPinMode,
        .currentSourceLockMode, .autoSwitchEn, .preferSecondRef,
        .refBufEnable, .extThreshSel, .firstRefLow, .secondRefLow,
        .vcoClkLow);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input string n, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask : wr

    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        regAddr <= a;
        tick(1);
        v = regRdata;
    endtask : rd

    task automatic upd();
        wr(ADDR_UPDATE, 8'h01);
        tick(2);
    endtask : upd

    task automatic results();
        $display("checked %0d errors %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic testRegs();
        rd(ADDR_HOLD);
        chk("holdReset", v, RESET_REG);
        chk("windowHigh", {7'h00, lockWindowHigh}, 8'h01);
        wr(ADDR_REF_SEL, 8'hFF);
        wr(ADDR_PIN_MON, 8'hC4);
        wr(10'h3FF, 8'h55);
        rd(10'h3FF);
        chk("unmapped", v, 8'h00);
        rd(ADDR_REF_SEL);
        chk("refSel", v, MASK_REF_SEL);
        chk("swBefore", {7'h00, autoSwitchEn}, 8'h00);
        upd();
        chk("autoSw", {6'h00, preferSecondRef, autoSwitchEn}, 8'h03);
        chk("bufEn", {6'h00, refBufEnable}, 8'h03);
        chk("pinMode", {2'h0, lockPinMode}, 8'h04);
        chk("csMode", {7'h00, currentSourceLockMode}, 8'h01);
        chk("thresh", {7'h00, extThreshSel}, 8'h01);
    endtask : testRegs

    task automatic testHold();
        wr(ADDR_LOCK_CAL, 8'h00);
        lockPinLevel <= 1'h0;
        wr(ADDR_HOLD, 8'h01);
        upd();
        fe.pulse(4, 1'h1);
        tick(2);
        chk("lock4", {7'h00, digitalLockFlag}, 8'h00);
        fe.pulse(1, 1'h1);
        tick(2);
        chk("lock5", {7'h00, digitalLockFlag}, 8'h01);
        fe.pulse(1, 1'h0);
        tick(3);
        chk("hiZ", {6'h00, holdoverActive, chargePumpHiZ}, 8'h03);
        tick(40);
        chk("hiZHeld", {7'h00, chargePumpHiZ}, 8'h01);
        fe.refPulse();
        #1;
        chk("release", {6'h00, swallowReset, chargePumpHiZ}, 8'h02);
        tick(1);
        chk("swPulse", {7'h00, swallowReset}, 8'h00);
        fe.pulse(3, 1'h1);
        fe.pulse(1, 1'h0);
        tick(3);
        chk("noReentry", {7'h00, chargePumpHiZ}, 8'h00);
        wr(ADDR_HOLD, 8'h03);
        upd();
        fe.pulse(6, 1'h1);
        fe.pulse(1, 1'h0);
        tick(3);
        chk("extBlocks", {7'h00, chargePumpHiZ}, 8'h00);
    endtask : testHold

    task automatic testPin();
        wr(ADDR_LOCK_CAL, 8'h10);
        wr(ADDR_HOLD, 8'h09);
        upd();
        chk("windowLow", {7'h00, lockWindowHigh}, 8'h00);
        fe.pulse(5, 1'h1);
        fe.pulse(1, 1'h0);
        tick(3);
        chk("pinLowBlocks", {7'h00, chargePumpHiZ}, 8'h00);
        @(posedge clk);
        lockPinLevel <= 1'h1;
        tick(3);
        chk("pinHighEnters", {7'h00, chargePumpHiZ}, 8'h01);
        fe.refPulse();
        lockPinLevel <= 1'h0;
        fe.pulse(5, 1'h1);
        fe.pulse(1, 1'h0);
        @(posedge clk);
        lockPinLevel <= 1'h1;
        tick(3);
        chk("pinLowNoArm", {7'h00, chargePumpHiZ}, 8'h00);
    endtask : testPin

    task automatic testCal();
        int n;
        n = int'(CAL_CYCLES) * int'(CAL_DIV_VALUES[0]);
        wr(ADDR_LOCK_CAL, 8'h01);
        upd();
        chk("calOn", {6'h00, calLoopOpen, outputSync}, 8'h03);
        chk("doneLow", {7'h00, calDone}, 8'h00);
        fe.pulse(n - 1, 1'h1);
        #1;
        chk("syncHeld", {7'h00, outputSync}, 8'h01);
        fe.pulse(1, 1'h1);
        tick(3);
        chk("calEnd", {6'h00, calLoopOpen, outputSync}, 8'h00);
        chk("monitors", {5'h00, vcoClkLow, secondRefLow, firstRefLow},
            8'h02);
        rd(ADDR_READBACK);
        chk("rbDone", {7'h00, v[RB_CAL_BIT]}, 8'h01);
        wr(ADDR_LOCK_CAL, 8'h03);
        upd();
        chk("noAutoCal", {7'h00, outputSync}, 8'h00);
        wr(ADDR_LOCK_CAL, 8'h00);
        upd();
        wr(ADDR_LOCK_CAL, 8'h01);
        upd();
        chk("recal", {6'h00, calDone, outputSync}, 8'h01);
    endtask : testCal

    task automatic testMon();
        wr(ADDR_PIN_MON, 8'h04);
        upd();
        @(posedge clk);
        clkInSelected <= 1'h1;
        fe.pulse(600, 1'h1);
        clkInSelected <= 1'h0;
        #1;
        chk("clkInMon", {5'h00, vcoClkLow, secondRefLow, firstRefLow},
            8'h06);
        fe.pulse(1, 1'h1);
        tick(1);
        chk("oscBack", {7'h00, vcoClkLow}, 8'h00);
    endtask : testMon

    task automatic testStrap();
        @(posedge clk);
        rst           <= 1'h1;
        autoLoadStrap <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        chk("strapCal", {6'h00, calDone, outputSync}, 8'h01);
        chk("rstHiZ", {7'h00, chargePumpHiZ}, 8'h00);
        tick(20);
        chk("strapWait", {7'h00, calDone}, 8'h00);
    endtask : testStrap

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        testRegs();
        testHold();
        testPin();
        testCal();
        testMon();
        testStrap();
        results();
    end

    initial begin
        #(30000 * 8);
        errorCnt++;
        results();
    end
endmodule : tb_top
`default_nettype wire
